// ---- qdsci_params.svh ----
// constants of the quad dac serial command interface
// Function
// R1: each command is 16 bits msb first; select held low through all bits
// R2: word is two select bits, two control bits, twelve code bits
// R3: control 01 loads selected input register only
// R4: control 11 loads selected input register then updates all outputs
// R5: code 0100 copies all inputs to outputs; restarts from shutdown
// R6: code 1000 writes code into all inputs and outputs; restarts
// R7: code 1100 enters shutdown only while lockout input is high
// R8: code 0010 drives user output low, 0110 drives it high
// R9: code 0000 changes nothing
// R10: code 1110 echo mode 1, 1010 mode 0; both update all outputs
// R11: echo starts in mode 0 after power-up
// R12: select high makes the interface ignore clock and data
// R13: data sampled into shift register on rising serial clock edges
// R14: host keeps serial clock at or below 10 MHz
// R15: commands execute on the rising edge of select
// R16: echo is last shift stage, lag 16.5 clocks mode 0, 16 mode 1
// R17: lockout low makes the device ignore the shutdown command
// R18: lockout falling while shut down wakes the device
// R19: daisy chain feeds echo to next input, nop skips devices
// R20: shared data line needs one select per device
// R21: clear resets all registers and drives user and echo outputs low; code leaves echo mode and shutdown as they were
// R22: power-up sets all registers to zero code
// R23: shutdown keeps input register contents
// R24: commands still accepted during shutdown
// R25: any output update leaves shutdown except shutdown itself
`ifndef QDSCI_PARAMS_SVH
`define QDSCI_PARAMS_SVH
`define QDSCI_WORD_BITS 16
`define QDSCI_CODE_BITS 12
`define QDSCI_CHANNELS 4
`define QDSCI_CMD_NOP 4'h0
`define QDSCI_CMD_UPO_LOW 4'h2
`define QDSCI_CMD_UPDATE_ALL 4'h4
`define QDSCI_CMD_UPO_HIGH 4'h6
`define QDSCI_CMD_LOAD_ALL 4'h8
`define QDSCI_CMD_MODE0 4'hA
`define QDSCI_CMD_SHUTDOWN 4'hC
`define QDSCI_CMD_MODE1 4'hE
`endif

// ---- qdsci_pkg.sv ----
// types of the quad dac serial command interface
package qdsci_pkg;
    typedef logic [11:0] qdsci_code_t;
    typedef struct packed {
        logic [1:0] cs_sync;
        logic [1:0] sclk_sync;
        logic [1:0] din_sync;
        logic [1:0] lock_sync;
        logic [1:0] clr_sync;
        logic sclk_prev;
        logic lock_prev;
        logic [15:0] shift;
        logic spill;
        logic [4:0] count;
        qdsci_code_t [3:0] in_reg;
        qdsci_code_t [3:0] out_reg;
        logic user_out;
        logic echo_mode;
        logic shutdown;
        logic echo;
    } qdsci_state_t;
endpackage : qdsci_pkg

// ---- qdsci_top.sv ----
// serial command interface of a quad 12-bit dac
`timescale 1ns/100ps
`include "qdsci_params.svh"
module qdsci_top
    import qdsci_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic clear_n,
    input wire logic shutdown_lockout_n,
    output logic dout,
    output logic user_logic_out,
    output logic shutdown,
    output logic echo_mode,
    output logic [47:0] dac_code
);
    qdsci_state_t s;
    qdsci_state_t next_s;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic cs_lo;
        logic rise;
        logic fall;
        logic [3:0] cmd;
        qdsci_code_t code;
        logic upd;
        next_s = s;
        cs_lo = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        cmd = 4'h0;
        code = 12'h000;
        upd = 1'b0;
        next_s.cs_sync = {s.cs_sync[0], cs_n};
        next_s.sclk_sync = {s.sclk_sync[0], sclk};
        next_s.din_sync = {s.din_sync[0], din};
        next_s.lock_sync = {s.lock_sync[0], shutdown_lockout_n};
        next_s.clr_sync = {s.clr_sync[0], clear_n};
        next_s.sclk_prev = s.sclk_sync[1];
        next_s.lock_prev = s.lock_sync[1];
        cs_lo = ~s.cs_sync[1]; // R12
        rise = s.sclk_sync[1] & ~s.sclk_prev;
        fall = ~s.sclk_sync[1] & s.sclk_prev;
        cmd = s.shift[15:12]; // R2
        code = s.shift[11:0];
        if (cs_lo && rise) begin
            // shift msb first; the echo stage is the bit falling off the top
            next_s.shift = {s.shift[14:0], s.din_sync[1]}; // R13 R1
            // the bit pushed out is kept so mode 0 can echo it half a cycle later
            next_s.spill = s.shift[15]; // R16
            if (s.count != 5'h10) begin
                next_s.count = s.count + 5'h01;
            end
            if (s.echo_mode) begin
                next_s.echo = s.shift[15]; // R16
            end
        end
        if (cs_lo && fall && !s.echo_mode) begin
            next_s.echo = s.spill; // R16
        end
        if (!cs_lo) begin
            next_s.count = 5'h00;
        end
        // execute on select rising, only once a full word has arrived
        if (!s.cs_sync[1] && next_s.cs_sync[1] == 1'b1 && s.cs_sync[0] && s.count == 5'h10) begin
            case (cmd) // R15
                `QDSCI_CMD_NOP: begin
                end // R9
                `QDSCI_CMD_UPO_LOW: next_s.user_out = 1'b0; // R8
                `QDSCI_CMD_UPO_HIGH: next_s.user_out = 1'b1; // R8
                `QDSCI_CMD_UPDATE_ALL: upd = 1'b1; // R5
                `QDSCI_CMD_LOAD_ALL: begin
                    for (int i = 0; i < `QDSCI_CHANNELS; i++) begin
                        next_s.in_reg[i] = code; // R6
                        next_s.out_reg[i] = code;
                    end
                    next_s.shutdown = 1'b0; // R25
                end
                `QDSCI_CMD_SHUTDOWN: begin
                    if (s.lock_sync[1]) begin
                        next_s.shutdown = 1'b1; // R7 R17
                    end
                end
                `QDSCI_CMD_MODE1: begin
                    next_s.echo_mode = 1'b1; // R10
                    upd = 1'b1;
                end
                `QDSCI_CMD_MODE0: begin
                    next_s.echo_mode = 1'b0; // R10
                    upd = 1'b1;
                end
                default: begin
                    if (cmd[0]) begin
                        next_s.in_reg[cmd[3:2]] = code; // R3
                        if (cmd[1]) begin
                            upd = 1'b1; // R4
                        end
                    end
                end
            endcase
            if (upd) begin
                for (int i = 0; i < `QDSCI_CHANNELS; i++) begin
                    next_s.out_reg[i] = next_s.in_reg[i];
                end
                next_s.shutdown = 1'b0; // R25 R24
            end
        end
        // wake on lockout falling; held registers are untouched
        if (s.lock_prev && !s.lock_sync[1]) begin
            next_s.shutdown = 1'b0; // R18 R23
        end
        if (!s.clr_sync[1]) begin
            for (int i = 0; i < `QDSCI_CHANNELS; i++) begin
                next_s.in_reg[i] = 12'h000; // R21
                next_s.out_reg[i] = 12'h000;
            end
            next_s.user_out = 1'b0;
            next_s.echo = 1'b0;
            next_s.shift = 16'h0000;
            next_s.spill = 1'b0;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0; // R22 R11
            s.cs_sync <= 2'h3;
            s.lock_sync <= 2'h3;
            s.clr_sync <= 2'h3;
            s.lock_prev <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign dout = s.echo;
    assign user_logic_out = s.user_out;
    assign shutdown = s.shutdown;
    assign echo_mode = s.echo_mode;
    assign dac_code = {s.out_reg[3], s.out_reg[2], s.out_reg[1], s.out_reg[0]};
endmodule : qdsci_top

// ---- qdsci_host.sv ----
// host serial master model driving select, clock and data
`timescale 1ns/100ps
module qdsci_host (
    output logic cs_n,
    output logic sclk,
    output logic din
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end
    // 200 ns period stays below the 10 MHz ceiling
    task automatic send(input logic [31:0] w, input int n);
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            din = w[i];
            #100 sclk = 1'b1;
            #100 sclk = 1'b0;
        end
        #100 cs_n = 1'b1;
        // released data line shows the inverse so a stale bit cannot pass
        din = ~din;
        #200;
    endtask : send
endmodule : qdsci_host

// ---- qdsci_props.sv ----
// assertions on the ports of the serial command interface
`timescale 1ns/100ps
module qdsci_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic clear_n,
    input wire logic shutdown_lockout_n,
    input wire logic dout,
    input wire logic user_logic_out,
    input wire logic shutdown,
    input wire logic echo_mode,
    input wire logic [47:0] dac_code
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_codes_hold_frame: assert property ((!cs_n && clear_n)[*8] |-> $stable(dac_code))
        else $error("codes moved inside a frame");
    a_upo_hold_frame: assert property ((!cs_n && clear_n)[*8] |-> $stable(user_logic_out))
        else $error("user output moved inside a frame");
    a_mode_hold_frame: assert property (!cs_n[*8] |-> $stable(echo_mode))
        else $error("echo mode moved inside a frame");
    a_codes_after_select: assert property ($changed(dac_code) && clear_n |-> $past(cs_n, 2))
        else $error("codes changed without select release");
    a_clear_zeros: assert property (!clear_n[*5] |-> dac_code == 48'h0 && !user_logic_out && !dout)
        else $error("clear did not zero outputs");
    a_lock_no_shut: assert property (!shutdown_lockout_n[*6] |-> !shutdown)
        else $error("shut down while lockout low");
    a_shut_needs_lock: assert property ($rose(shutdown) |-> shutdown_lockout_n)
        else $error("shutdown entered with lockout low");
    a_echo_quiet: assert property ((clear_n && $stable(sclk))[*6] |-> $stable(dout))
        else $error("echo moved without a clock edge");
    c_shut: cover property ($rose(shutdown));
    c_mode: cover property ($rose(echo_mode));
    c_upo: cover property ($rose(user_logic_out));
endmodule : qdsci_props

// ---- tb_top.sv ----
// testbench for the quad dac serial command interface
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0, rst = 1'b1, clear_n = 1'b1, lock_n = 1'b1;
    logic cs_n, sclk, din, dout, ulo, sd, em;
    logic [47:0] dac;
    int fail_count = 0, n_checks = 0, cycles = 0;
    always #12.5 clk = ~clk;
    qdsci_host host_u (.cs_n(cs_n), .sclk(sclk), .din(din));
    qdsci_top dut_u (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din),
        .clear_n(clear_n), .shutdown_lockout_n(lock_n), .dout(dout),
        .user_logic_out(ulo), .shutdown(sd), .echo_mode(em), .dac_code(dac));
    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cmd(input logic [31:0] w, input int n = 16);
        @(negedge clk);
        host_u.send(w, n);
    endtask : cmd
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk("codes", 48'h0, dac);
        chk("mode", 48'h0, {47'h0, em});
        cmd(16'h1123);
        chk("codes", 48'h0, dac);
        cmd(16'h7456);
        chk("codes", 48'h000000456123, dac);
        cmd(16'hC000);
        chk("shut", 48'h1, {47'h0, sd});
        cmd(16'h9789);
        cmd(16'h4000);
        chk("codes", 48'h000789456123, dac);
        chk("shut", 48'h0, {47'h0, sd});
        cmd(16'h008A, 8);
        chk("codes", 48'h000789456123, dac);
        cmd(16'h8ABC);
        chk("codes", 48'hABCABCABCABC, dac);
        cmd(16'h0FFF);
        chk("codes", 48'hABCABCABCABC, dac);
        cmd(16'hE000);
        chk("mode", 48'h1, {47'h0, em});
        cmd(16'hA000);
        chk("mode", 48'h0, {47'h0, em});
        cmd(16'h2000);
        chk("upo", 48'h0, {47'h0, ulo});
        lock_n = 1'b0;
        cmd(16'hC000);
        chk("shut", 48'h0, {47'h0, sd});
        lock_n = 1'b1;
        cmd(16'hC000);
        chk("shut", 48'h1, {47'h0, sd});
        @(negedge clk);
        lock_n = 1'b0;
        repeat (8) @(negedge clk);
        chk("shut", 48'h0, {47'h0, sd});
        cmd(32'h00003DEF, 32);
        chk("codes", 48'hABCABCABCDEF, dac);
        cmd(16'h6000);
        chk("upo", 48'h1, {47'h0, ulo});
        chk("echo", 48'h1, {47'h0, dout});
        @(negedge clk);
        clear_n = 1'b0;
        repeat (8) @(negedge clk);
        chk("cleared", 48'h0, {dac[47:1], dac[0] | ulo | dout});
        clear_n = 1'b1;
        results();
    end
endmodule : tb_top
bind qdsci_top qdsci_props props_u (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk),
    .clear_n(clear_n), .shutdown_lockout_n(shutdown_lockout_n), .dout(dout),
    .user_logic_out(user_logic_out), .shutdown(shutdown), .echo_mode(echo_mode),
    .dac_code(dac_code));
